//--- logic/lpd_defines.vh
// constants for the sixteen-channel led sink driver
`ifndef LPD_DEFINES_VH
`define LPD_DEFINES_VH
// register indices; byte address on the register bus is four times these
`define LPD_IDX_MODE 5'h00
`define LPD_IDX_GDUTY 5'h01
`define LPD_IDX_GFREQ 5'h02
`define LPD_IDX_BRT0 5'h03
`define LPD_IDX_OMODE0 5'h13
`define LPD_IDX_BCAST 5'h17
`define LPD_IDX_SUB1 5'h18
`define LPD_IDX_SUB3 5'h1a
`define LPD_IDX_STATUS 5'h1b
`define LPD_NUM_RW 5'h1b
// mode register fields
`define LPD_MODE_BCAST_EN 0
`define LPD_MODE_SUB_LO 1
`define LPD_MODE_BLINK 4
`define LPD_MODE_UPD_ACK 5
// reset values
`define LPD_RST_MODE 8'h01
`define LPD_RST_GDUTY 8'hff
`define LPD_RST_BCAST 8'h70
`define LPD_RST_SUB1 8'h71
`define LPD_RST_SUB2 8'h72
`define LPD_RST_SUB3 8'h74
// reset call address byte, write direction only
`define LPD_RCALL_BYTE 8'h06
// output selector codes
`define LPD_OM_OFF 2'h0
`define LPD_OM_ON 2'h1
`define LPD_OM_IND 2'h2
`define LPD_OM_GRP 2'h3
// timing
`define LPD_PCLK_MHZ 200
`define LPD_OSC_MHZ 25
`define LPD_GLITCH_NS 50
`define LPD_BLINK_STEP_NS 162760
`endif

//--- logic/lpd_led_driver.v
// sixteen-channel led sink driver: serial slave, apb registers, pwm
//
// Summary of operation
// - per-output 8-bit pwm near 97 kHz
// - group pwm dims combined-mode outputs near 190 Hz
// - blink period programmable, 24 Hz to 10.67 s
// - each output off, on, individual, or combined
// - active-low gate pin controls all outputs
// - reset call equals power-on reset
// - outputs update on acknowledge or stop
// - own address taken from seven strap pins
// - broadcast and three subaddresses, separately enabled
// - brightness resets to fully off, linear
// - group duty resets to maximum
// - timing derived from 25 MHz oscillator
// - serial clock and data inputs are filtered
// - outputs glitch-free, off until reset ends
// - broadcast enabled at reset, subaddresses disabled
// - reset call acknowledged only for write
// - last address bit selects read or write
`timescale 1ns/1ps
`include "lpd_defines.vh"
module lpd_led_driver #(
	parameter BLINK_STEP_CYC = `LPD_BLINK_STEP_NS * `LPD_PCLK_MHZ / 1000
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// serial bus pins
	input wire scl_in,
	input wire sda_in,
	output wire sda_out,
	output wire sda_oe,
	// strap and gate pins
	input wire [6:0] strap_bit,
	input wire gate_n,
	// open-drain sinks, 1 = released (led off)
	output wire [15:0] sink_output
);
	localparam OSC_DIV = `LPD_PCLK_MHZ / `LPD_OSC_MHZ;
	localparam FILT_CYC = `LPD_GLITCH_NS * `LPD_PCLK_MHZ / 1000;
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_ADDR = 7'h02;
	localparam [6:0] S_AACK = 7'h04;
	localparam [6:0] S_WR = 7'h08;
	localparam [6:0] S_WACK = 7'h10;
	localparam [6:0] S_RD = 7'h20;
	localparam [6:0] S_RACK = 7'h40;

	// reset value of each register
	function [7:0] rst_val;
		input [4:0] idx;
		begin
			case (idx)
				`LPD_IDX_MODE: rst_val = `LPD_RST_MODE;
				`LPD_IDX_GDUTY: rst_val = `LPD_RST_GDUTY;
				`LPD_IDX_BCAST: rst_val = `LPD_RST_BCAST;
				`LPD_IDX_SUB1: rst_val = `LPD_RST_SUB1;
				`LPD_IDX_SUB1 + 5'h01: rst_val = `LPD_RST_SUB2;
				`LPD_IDX_SUB3: rst_val = `LPD_RST_SUB3;
				default: rst_val = 8'h00;
			endcase
		end
	endfunction

	reg [7:0] cfg_ff [0:26];
	reg [7:0] act_ff [0:26];
	reg [1:0] gate_sync_ff;
	reg [6:0] strap_s1_ff;
	reg [6:0] strap_ff;
	reg [1:0] scl_sync_ff;
	reg [1:0] sda_sync_ff;
	reg scl_f_ff;
	reg sda_f_ff;
	reg [3:0] scl_cnt_ff;
	reg [3:0] sda_cnt_ff;
	reg scl_d_ff;
	reg sda_d_ff;
	reg [6:0] st_ff;
	reg [3:0] bit_ff;
	reg [7:0] sh_ff;
	reg [4:0] ptr_ff;
	reg first_ff;
	reg rcall_ff;
	reg drv_ff;
	reg pend_ff;
	reg srst_ff;
	reg upd_ff;
	reg i2c_we_ff;
	reg [7:0] i2c_wd_ff;
	reg [31:0] prdata_ff;
	reg [2:0] osc_ff;
	reg [7:0] pwm_ff;
	reg dim_half_ff;
	reg [15:0] pre_ff;
	reg [7:0] fcnt_ff;
	reg [7:0] grp_ff;
	reg [15:0] sink_ff;
	integer k;
	integer j;

	// register read, status holds gate level and strap address
	function [7:0] rd_byte;
		input [4:0] idx;
		begin
			if (idx == `LPD_IDX_STATUS)
				rd_byte = {gate_sync_ff[1], strap_ff};
			else if (idx < `LPD_IDX_STATUS)
				rd_byte = cfg_ff[idx];
			else
				rd_byte = 8'h00;
		end
	endfunction

	wire [4:0] apb_idx = paddr[6:2];
	wire apb_bad = (paddr[1:0] != 2'h0) | paddr[7] |
		(apb_idx > `LPD_IDX_STATUS);
	wire apb_we = psel & penable & pwrite & ~apb_bad &
		(apb_idx != `LPD_IDX_STATUS);
	wire [7:0] mode = cfg_ff[`LPD_IDX_MODE];

	// apb answers at once; read data captured in the setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & apb_bad;
	assign prdata = prdata_ff;
	assign sda_out = 1'b0;
	assign sda_oe = drv_ff;
	assign sink_output = sink_ff;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_ff <= 32'h0;
		else if (psel & ~penable & ~apb_bad)
			prdata_ff <= {24'h0, rd_byte(apb_idx)};
	end

	// two-flop synchronisers on every pin input
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_sync_ff <= 2'h3;
			strap_s1_ff <= 7'h0;
			strap_ff <= 7'h0;
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
		end else begin
			gate_sync_ff <= {gate_sync_ff[0], gate_n};
			strap_s1_ff <= strap_bit;
			strap_ff <= strap_s1_ff;
			scl_sync_ff <= {scl_sync_ff[0], scl_in};
			sda_sync_ff <= {sda_sync_ff[0], sda_in};
		end
	end

	// noise filter: a level must hold FILT_CYC cycles to pass
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_f_ff <= 1'b1;
			sda_f_ff <= 1'b1;
			scl_cnt_ff <= 4'h0;
			sda_cnt_ff <= 4'h0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_f_ff;
			sda_d_ff <= sda_f_ff;
			if (scl_sync_ff[1] == scl_f_ff)
				scl_cnt_ff <= 4'h0;
			else if (scl_cnt_ff == FILT_CYC[3:0] - 4'h1) begin
				scl_f_ff <= scl_sync_ff[1];
				scl_cnt_ff <= 4'h0;
			end else
				scl_cnt_ff <= scl_cnt_ff + 4'h1;
			if (sda_sync_ff[1] == sda_f_ff)
				sda_cnt_ff <= 4'h0;
			else if (sda_cnt_ff == FILT_CYC[3:0] - 4'h1) begin
				sda_f_ff <= sda_sync_ff[1];
				sda_cnt_ff <= 4'h0;
			end else
				sda_cnt_ff <= sda_cnt_ff + 4'h1;
		end
	end

	wire scl_rise = scl_f_ff & ~scl_d_ff;
	wire scl_fall = ~scl_f_ff & scl_d_ff;
	wire start_c = scl_f_ff & scl_d_ff & ~sda_f_ff & sda_d_ff;
	wire stop_c = scl_f_ff & scl_d_ff & sda_f_ff & ~sda_d_ff;
	wire [6:0] a7 = sh_ff[7:1];
	wire sub_hit = (mode[1] & (a7 == cfg_ff[`LPD_IDX_SUB1][6:0])) |
		(mode[2] & (a7 == cfg_ff[`LPD_IDX_SUB1 + 5'h01][6:0])) |
		(mode[3] & (a7 == cfg_ff[`LPD_IDX_SUB3][6:0]));
	wire bc_hit = mode[`LPD_MODE_BCAST_EN] &
		(a7 == cfg_ff[`LPD_IDX_BCAST][6:0]);
	wire rc_hit = (sh_ff == `LPD_RCALL_BYTE);
	wire addr_hit = (a7 == strap_ff) | bc_hit | sub_hit;
	wire [4:0] ptr_inc = (ptr_ff == `LPD_IDX_STATUS) ? 5'h00 :
		ptr_ff + 5'h01;
	wire [7:0] tx_byte = rd_byte(ptr_ff);

	// serial slave: address, pointer, write and read bytes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= S_IDLE;
			bit_ff <= 4'h0;
			sh_ff <= 8'h0;
			ptr_ff <= 5'h0;
			first_ff <= 1'b0;
			rcall_ff <= 1'b0;
			drv_ff <= 1'b0;
			pend_ff <= 1'b0;
			srst_ff <= 1'b0;
			upd_ff <= 1'b0;
			i2c_we_ff <= 1'b0;
			i2c_wd_ff <= 8'h0;
		end else begin
			srst_ff <= 1'b0;
			i2c_we_ff <= 1'b0;
			upd_ff <= apb_we | (i2c_we_ff & mode[`LPD_MODE_UPD_ACK]);
			// pointer steps after each written byte, wraps past status
			if (i2c_we_ff)
				ptr_ff <= ptr_inc;
			if (start_c) begin
				st_ff <= S_ADDR;
				bit_ff <= 4'h0;
				drv_ff <= 1'b0;
				rcall_ff <= 1'b0;
			end else if (stop_c) begin
				st_ff <= S_IDLE;
				drv_ff <= 1'b0;
				srst_ff <= rcall_ff;
				rcall_ff <= 1'b0;
				upd_ff <= pend_ff;
				pend_ff <= 1'b0;
			end else begin
				case (st_ff)
					S_IDLE: drv_ff <= 1'b0;
					S_ADDR, S_WR: begin
						if (scl_rise) begin
							sh_ff <= {sh_ff[6:0], sda_f_ff};
							bit_ff <= bit_ff + 4'h1;
						end else if (scl_fall && bit_ff == 4'h8) begin
							bit_ff <= 4'h0;
							if (st_ff == S_ADDR) begin
								first_ff <= 1'b1;
								rcall_ff <= rc_hit;
								drv_ff <= rc_hit | addr_hit;
								st_ff <= (rc_hit | addr_hit) ? S_AACK : S_IDLE;
							end else if (rcall_ff) begin
								st_ff <= S_IDLE; // extra bytes not taken
							end else begin
								drv_ff <= 1'b1;
								st_ff <= S_WACK;
								first_ff <= 1'b0;
								if (first_ff)
									ptr_ff <= sh_ff[4:0];
								else begin
									i2c_we_ff <= 1'b1;
									i2c_wd_ff <= sh_ff;
									pend_ff <= ~mode[`LPD_MODE_UPD_ACK];
								end
							end
						end
					end
					S_AACK: begin
						if (scl_fall) begin
							if (sh_ff[0] & ~rcall_ff) begin
								st_ff <= S_RD;
								sh_ff <= {tx_byte[6:0], 1'b0};
								drv_ff <= ~tx_byte[7];
								bit_ff <= 4'h1;
							end else begin
								st_ff <= S_WR;
								drv_ff <= 1'b0;
							end
						end
					end
					S_WACK: begin
						if (scl_fall) begin
							drv_ff <= 1'b0;
							st_ff <= S_WR;
						end
					end
					S_RD: begin
						if (scl_fall) begin
							if (bit_ff == 4'h8) begin
								drv_ff <= 1'b0;
								st_ff <= S_RACK;
								ptr_ff <= ptr_inc;
							end else begin
								drv_ff <= ~sh_ff[7];
								sh_ff <= {sh_ff[6:0], 1'b0};
								bit_ff <= bit_ff + 4'h1;
							end
						end
					end
					S_RACK: begin
						if (scl_rise && sda_f_ff)
							st_ff <= S_IDLE; // master nack ends the read
						else if (scl_fall) begin
							st_ff <= S_RD;
							sh_ff <= {tx_byte[6:0], 1'b0};
							drv_ff <= ~tx_byte[7];
							bit_ff <= 4'h1;
						end
					end
					default: st_ff <= S_IDLE;
				endcase
			end
		end
	end

	// register file, written from apb or the serial bus
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (k = 0; k < 27; k = k + 1)
				cfg_ff[k] <= rst_val(k[4:0]);
		end else if (srst_ff) begin
			for (k = 0; k < 27; k = k + 1)
				cfg_ff[k] <= rst_val(k[4:0]);
		end else if (i2c_we_ff && ptr_ff < `LPD_NUM_RW) begin
			cfg_ff[ptr_ff] <= i2c_wd_ff;
			if (apb_we && apb_idx != ptr_ff)
				cfg_ff[apb_idx] <= pwdata[7:0];
		end else if (apb_we)
			cfg_ff[apb_idx] <= pwdata[7:0];
	end

	// active copy that the outputs follow
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < 27; j = j + 1)
				act_ff[j] <= rst_val(j[4:0]);
		end else if (srst_ff) begin
			for (j = 0; j < 27; j = j + 1)
				act_ff[j] <= rst_val(j[4:0]);
		end else if (upd_ff) begin
			for (j = 0; j < 27; j = j + 1)
				act_ff[j] <= cfg_ff[j];
		end
	end

	// 25 MHz timebase and the individual pwm ramp
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_ff <= 3'h0;
			pwm_ff <= 8'h0;
			dim_half_ff <= 1'b0;
		end else if (srst_ff) begin
			osc_ff <= 3'h0;
			pwm_ff <= 8'h0;
			dim_half_ff <= 1'b0;
		end else begin
			osc_ff <= (osc_ff == OSC_DIV[2:0] - 3'h1) ? 3'h0 :
				osc_ff + 3'h1;
			if (osc_ff == OSC_DIV[2:0] - 3'h1) begin
				pwm_ff <= pwm_ff + 8'h1;
				if (pwm_ff == 8'hff)
					dim_half_ff <= ~dim_half_ff;
			end
		end
	end

	wire osc_tick = (osc_ff == OSC_DIV[2:0] - 3'h1);
	wire blink = act_ff[`LPD_IDX_MODE][`LPD_MODE_BLINK];
	wire dim_step = osc_tick & (pwm_ff == 8'hff) & dim_half_ff;
	wire pre_end = (pre_ff == BLINK_STEP_CYC[15:0] - 16'h1);
	wire blink_step = pre_end & (fcnt_ff == act_ff[`LPD_IDX_GFREQ]);

	// group ramp: two pwm periods per step dims, prescaler blinks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff <= 16'h0;
			fcnt_ff <= 8'h0;
			grp_ff <= 8'h0;
		end else if (srst_ff) begin
			pre_ff <= 16'h0;
			fcnt_ff <= 8'h0;
			grp_ff <= 8'h0;
		end else begin
			pre_ff <= pre_end ? 16'h0 : pre_ff + 16'h1;
			if (blink_step)
				fcnt_ff <= 8'h0;
			else if (pre_end)
				fcnt_ff <= fcnt_ff + 8'h1;
			if (blink ? blink_step : dim_step)
				grp_ff <= grp_ff + 8'h1;
		end
	end

	wire grp_on = grp_ff < act_ff[`LPD_IDX_GDUTY];

	// per-output selector, gate and sink drive
	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_out
			wire [7:0] om_byte = act_ff[`LPD_IDX_OMODE0 + g / 4];
			wire [1:0] om = om_byte[2 * (g % 4) +: 2];
			wire ind_on = pwm_ff < act_ff[`LPD_IDX_BRT0 + g];
			wire lit = (om == `LPD_OM_ON) |
				((om == `LPD_OM_IND) & ind_on) |
				((om == `LPD_OM_GRP) & ind_on & grp_on);
			always @(posedge pclk or negedge presetn) begin
				if (!presetn)
					sink_ff[g] <= 1'b1;
				else if (srst_ff)
					sink_ff[g] <= 1'b1;
				else
					sink_ff[g] <= ~(lit & ~gate_sync_ff[1]);
			end
		end
	endgenerate
endmodule // lpd_led_driver

//--- verif/lpd_led_driver_sva.sv
// assertion checker on the ports of the led sink driver
`timescale 1ns/1ps
module lpd_led_driver_sva (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb
	input wire psel,
	input wire penable,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	// serial and pins
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe,
	input wire gate_n,
	input wire [15:0] sink_output
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// outputs stay released just after reset
	AST_RST_OFF: assert property (
		$rose(presetn) |-> (&sink_output)[*3])
		else $error("sinks not released after reset");
	// gate high releases all sinks after the synchroniser
	AST_GATE_OFF: assert property (
		gate_n[*4] |=> &sink_output)
		else $error("sink active while gate high");
	// data line moves only while the clock line is low
	AST_SDA_SCL_LOW: assert property (
		$changed(sda_oe) |-> !scl_in)
		else $error("sda changed with scl high");
	// a pull comes only after the filtered clock fall
	AST_SDA_FILTER: assert property (
		$rose(sda_oe) |-> $past(scl_in, 10) == 1'b0)
		else $error("sda pulled before filter delay");
	// a pull, acknowledge or data bit, is held at least eight more cycles
	AST_ACK_HOLD: assert property (
		$rose(sda_oe) |=> sda_oe[*8])
		else $error("acknowledge too short");
	// the data pin only ever pulls low
	AST_SDA_OD: assert property (
		sda_out == 1'b0)
		else $error("sda driven high");
	// registers answer with no wait
	AST_PREADY: assert property (
		psel && penable |-> pready)
		else $error("wait state inserted");
	// accesses past the map are refused
	AST_ERR_HI: assert property (
		psel && penable && paddr >= 8'h70 |-> pslverr)
		else $error("unmapped access accepted");
	// aligned accesses in the map are accepted
	AST_ERR_LO: assert property (
		psel && penable && paddr < 8'h70 && paddr[1:0] == 2'h0
		|-> !pslverr)
		else $error("mapped access refused");
	COV_ACK: cover property ($rose(sda_oe));
	COV_GATE: cover property ($fell(gate_n));
	COV_ERR: cover property (psel && penable && pslverr);
endmodule // lpd_led_driver_sva
bind lpd_led_driver lpd_led_driver_sva chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .gate_n(gate_n),
	.sink_output(sink_output));

//--- verif/lpd_i2c_master.sv
// serial bus master model for the led sink driver
`timescale 1ns/1ps
module lpd_i2c_master (
	// serial bus
	output logic scl,
	output logic sda_low,
	input wire sda
);
	logic lclk = 1'b0;
	// bus tick, phase unrelated to pclk
	always #32 lclk = ~lclk;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge lclk);
	endtask
	// start condition, address byte follows
	task automatic start();
		tick(1);
		sda_low <= 1'b1;
		tick(2);
		scl <= 1'b0;
		tick(1);
	endtask
	// byte msb first, then sample acknowledge
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i];
			tick(2);
			scl <= 1'b1;
			tick(2);
			scl <= 1'b0;
			tick(1);
		end
		sda_low <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(1);
		ack = ~sda;
		tick(1);
		scl <= 1'b0;
		tick(1);
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		tick(1);
		scl <= 1'b1;
		tick(2);
		sda_low <= 1'b0;
		tick(4);
	endtask
endmodule // lpd_i2c_master

//--- verif/lpd_led_driver_tb.sv
// self-checking bench for the led sink driver
`timescale 1ns/1ps
module lpd_led_driver_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic gate_n = 1'b0;
	// strap clear of the reset call and broadcast values
	logic [6:0] strap_bit = 7'h15;
	wire [31:0] prdata;
	wire pready, pslverr, sda_out, sda_oe, scl, sda_low;
	wire [15:0] sink_output;
	// pulled-up data line
	wire sda_line = ~(sda_low | sda_oe);
	int err_total = 0;
	int check_count = 0;
	logic [31:0] rd;
	logic perr;
	logic ack;
	always #2.5 pclk = ~pclk;
	lpd_led_driver #(.BLINK_STEP_CYC(8)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe(sda_oe), .strap_bit(strap_bit), .gate_n(gate_n),
		.sink_output(sink_output));
	lpd_i2c_master mst (.scl(scl), .sda_low(sda_low), .sda(sda_line));
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// reset values, status and a refused address
	task automatic t_defaults();
		logic [7:0] a[6] = '{8'h00, 8'h04, 8'h0c, 8'h5c, 8'h60, 8'h68};
		logic [7:0] e[6] = '{8'h01, 8'hff, 8'h00, 8'h70, 8'h71, 8'h74};
		check("sinks", sink_output, 16'hffff);
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, a[i], 32'h0);
			check("default", rd, {24'h0, e[i]});
		end
		apb(1'b0, 8'h6c, 32'h0);
		check("status", rd, 32'h15);
		apb(1'b1, 8'h70, 32'h0);
		check("pslverr", perr, 1'b1);
	endtask
	// off, on, own pwm, own pwm with group at zero duty, then gate
	task automatic t_modes();
		int n[4];
		apb(1'b1, 8'h14, 32'h80);
		apb(1'b1, 8'h18, 32'h80);
		apb(1'b1, 8'h04, 32'h00);
		apb(1'b1, 8'h4c, 32'he4);
		repeat (2100) @(posedge pclk);
		repeat (2048) begin
			@(posedge pclk);
			for (int i = 0; i < 4; i++) n[i] += !sink_output[i];
		end
		check("off", n[0], 0);
		check("on", n[1], 2048);
		check("duty", n[2], 1024);
		check("group", n[3], 0);
		gate_n <= 1'b1;
		repeat (5) @(posedge pclk);
		check("gated", sink_output, 16'hffff);
		gate_n <= 1'b0;
		repeat (5) @(posedge pclk);
		check("ungated", sink_output[1], 1'b0);
	endtask
	// serial writes, address matching and the reset call
	task automatic t_serial();
		mst.start();
		mst.send({7'h15, 1'b0}, ack);
		check("own ack", ack, 1'b1);
		mst.send(8'h03, ack);
		mst.send(8'h5a, ack);
		mst.stop();
		apb(1'b0, 8'h0c, 32'h0);
		check("written", rd, 32'h5a);
		mst.start();
		mst.send(8'he0, ack);
		mst.stop();
		check("bcast ack", ack, 1'b1);
		mst.start();
		mst.send(8'he2, ack);
		mst.stop();
		check("sub ack", ack, 1'b0);
		mst.start();
		mst.send(8'h07, ack);
		mst.stop();
		check("rcall read", ack, 1'b0);
		mst.start();
		mst.send(8'h06, ack);
		mst.stop();
		check("rcall ack", ack, 1'b1);
		apb(1'b0, 8'h0c, 32'h0);
		check("rst brt", rd, 32'h0);
		apb(1'b0, 8'h4c, 32'h0);
		check("rst sel", rd, 32'h0);
		check("rst sinks", sink_output, 16'hffff);
		// first subaddress answers once software enables it
		apb(1'b1, 8'h00, 32'h03);
		mst.start();
		mst.send(8'he2, ack);
		mst.stop();
		check("sub1 ack", ack, 1'b1);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_modes();
		t_serial();
		test_done();
	end
	// watchdog against a hang
	initial begin
		#400000;
		err_total++;
		test_done();
	end
endmodule // lpd_led_driver_tb
